/* File: rtl/ssc_pkg.sv */
package ssc_pkg;
	// register map, management device space
	localparam logic [15:0] SSC_OFS_SOFT_RESET     = 16'hFF0C;
	localparam logic [15:0] SSC_OFS_STRAP_RESAMPLE = 16'hFF0D;
	localparam logic [15:0] SSC_OFS_CLK_SEL        = 16'hFF1F;
	localparam logic [15:0] SSC_RST_VAL            = 16'h0000;
	localparam int          SSC_BIT_SOFT_RESET     = 0;
	localparam int          SSC_BIT_RESAMPLE       = 0;
	localparam int          SSC_CLK_SEL_W          = 6;
	localparam int          SSC_BIT_RCVR_125       = 5;
	localparam int          SSC_BIT_FREE_125       = 4;
	localparam int          SSC_BIT_HRT_RCVR       = 2;
	localparam int          SSC_BIT_HRT_FREE       = 1;
	localparam int          SSC_BIT_REF_25         = 0;
	localparam int          SSC_STRAP_W            = 8;
	// serial management framing
	localparam logic [4:0]  SSC_DEVAD              = 5'h1E;
	localparam logic [4:0]  SSC_C22_PTR            = 5'h10;
	localparam logic [4:0]  SSC_C22_DATA           = 5'h11;
	localparam logic [1:0]  SSC_C45_OP_ADDR        = 2'h0;
	localparam logic [1:0]  SSC_C45_OP_WR          = 2'h1;
	localparam logic [1:0]  SSC_C45_OP_RDINC       = 2'h2;
	localparam logic [1:0]  SSC_C22_OP_WR          = 2'h1;
	localparam logic [1:0]  SSC_C22_OP_RD          = 2'h2;
	localparam logic [5:0]  SSC_PRE_BITS           = 6'h20;
	localparam logic [5:0]  SSC_HDR_BITS           = 6'h0D;
	localparam logic [5:0]  SSC_DATA_BITS          = 6'h10;
	// timing
	localparam int          SSC_CLK_PERIOD_NS      = 4;
	localparam int          SSC_SRST_HOLD_NS       = 100;
	localparam int          SSC_SRST_CYC           =
		(SSC_SRST_HOLD_NS + SSC_CLK_PERIOD_NS - 1) / SSC_CLK_PERIOD_NS;
	localparam int          SSC_STRAP_SETTLE       = 3;
	localparam int          SSC_SEQ_CNT_W          = 6;
endpackage

/* File: rtl/ssc_mdio_slave.sv */
`timescale 1ns/100ps
module ssc_mdio_slave import ssc_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [15:0] rd_data,
	output logic             mdio_out,
	output logic             mdio_oe_n,
	output logic [15:0]      reg_addr,
	output logic [15:0]      wr_data,
	output logic             wr_stb
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HDR  = 4'h2,
		ST_TA   = 4'h4,
		ST_DATA = 4'h8
	} ssc_mst_t;

	ssc_mst_t    state_r, state_nxt;
	logic [5:0]  cnt_r, cnt_nxt;
	logic [12:0] hdr_r, hdr_nxt;
	logic [15:0] sh_r, sh_nxt, addr_r, addr_nxt, wdat_r, wdat_nxt;
	logic        oen_r, oen_nxt, out_r, out_nxt, wstb_r, wstb_nxt;
	logic        mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
	logic        rise, c45, sel, is_rd;
	logic [1:0]  op;
	logic [15:0] rd_val;

	assign rise   = mdc_s2 & ~mdc_s3;
	assign c45    = ~hdr_r[12];
	assign op     = hdr_r[11:10];
	assign sel    = (hdr_r[9:5] == phy_addr) && (c45 ? (hdr_r[4:0] == SSC_DEVAD) :
		(hdr_r[4:0] == SSC_C22_PTR || hdr_r[4:0] == SSC_C22_DATA));
	assign is_rd  = c45 ? op[1] : (op == SSC_C22_OP_RD);
	assign rd_val = (!c45 && hdr_r[4:0] == SSC_C22_PTR) ? addr_r : rd_data;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		hdr_nxt   = hdr_r;
		sh_nxt    = sh_r;
		addr_nxt  = addr_r;
		oen_nxt   = oen_r;
		out_nxt   = out_r;
		wdat_nxt  = wdat_r;
		wstb_nxt  = 1'b0;
		if (rise) begin
			case (state_r)
			ST_IDLE: begin
				if (mdio_s2) begin
					cnt_nxt = (cnt_r == SSC_PRE_BITS) ? cnt_r : cnt_r + 6'h01;
				end else begin
					if (cnt_r == SSC_PRE_BITS)
						state_nxt = ST_HDR;
					cnt_nxt = 6'h00;
				end
			end
			ST_HDR: begin
				hdr_nxt = {hdr_r[11:0], mdio_s2};
				cnt_nxt = cnt_r + 6'h01;
				if (cnt_r == SSC_HDR_BITS - 6'h01) begin
					state_nxt = ST_TA;
					cnt_nxt   = 6'h00;
				end
			end
			ST_TA: begin
				cnt_nxt = cnt_r + 6'h01;
				if (cnt_r == 6'h00) begin
					// only the addressed device turns the line round
					if (sel && is_rd) begin
						oen_nxt = 1'b0;
						out_nxt = 1'b0;
						sh_nxt  = rd_val;
					end
				end else begin
					state_nxt = ST_DATA;
					cnt_nxt   = 6'h00;
					if (!oen_r) begin
						out_nxt = sh_r[15];
						sh_nxt  = {sh_r[14:0], 1'b0};
					end
				end
			end
			ST_DATA: begin
				sh_nxt  = {sh_r[14:0], mdio_s2};
				cnt_nxt = cnt_r + 6'h01;
				if (!oen_r)
					out_nxt = sh_r[15];
				if (cnt_r == SSC_DATA_BITS - 6'h01) begin
					state_nxt = ST_IDLE;
					cnt_nxt   = 6'h00;
					oen_nxt   = 1'b1;
					out_nxt   = 1'b0;
					if (sel && !is_rd) begin
						if (c45 && op == SSC_C45_OP_ADDR)
							addr_nxt = sh_nxt;
						else if (!c45 && hdr_r[4:0] == SSC_C22_PTR)
							addr_nxt = sh_nxt;
						else begin
							wstb_nxt = 1'b1;
							wdat_nxt = sh_nxt;
						end
					end
					if (sel && c45 && op == SSC_C45_OP_RDINC)
						addr_nxt = addr_r + 16'h0001;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt   = 6'h00;
			end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		// first stage feeds only the second
		mdc_s1  <= mdc;
		mdc_s2  <= mdc_s1;
		mdio_s1 <= mdio_in;
		mdio_s2 <= mdio_s1;
		if (reset) begin
			mdc_s3  <= 1'b0;
			state_r <= ST_IDLE;
			cnt_r   <= 6'h00;
			hdr_r   <= 13'h0000;
			sh_r    <= 16'h0000;
			addr_r  <= 16'h0000;
			oen_r   <= 1'b1;
			out_r   <= 1'b0;
			wdat_r  <= 16'h0000;
			wstb_r  <= 1'b0;
		end else begin
			mdc_s3  <= mdc_s2;
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			hdr_r   <= hdr_nxt;
			sh_r    <= sh_nxt;
			addr_r  <= addr_nxt;
			oen_r   <= oen_nxt;
			out_r   <= out_nxt;
			wdat_r  <= wdat_nxt;
			wstb_r  <= wstb_nxt;
		end
	end

	assign mdio_out  = out_r;
	assign mdio_oe_n = oen_r;
	assign reg_addr  = addr_r;
	assign wr_data   = wdat_r;
	assign wr_stb    = wstb_r;

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	a_wr_needs_match: assert property (wr_stb |-> $past(sel && !is_rd))
		else $error("write strobe without an addressed write frame");
	a_drive_only_read: assert property (!oen_r |-> sel && is_rd)
		else $error("line driven outside an addressed read");
endmodule // ssc_mdio_slave

/* File: rtl/ssc_subsys_ctrl.sv */
`timescale 1ns/100ps
module ssc_subsys_ctrl import ssc_pkg::*; (
	input  wire logic                   mclk,
	input  wire logic                   reset,
	input  wire logic                   mdc,
	input  wire logic                   mdio_in,
	output logic                        mdio_out,
	output logic                        mdio_oe_n,
	input  wire logic [4:0]             phy_addr,
	input  wire logic [SSC_STRAP_W-1:0] strap_pins,
	input  wire logic                   clk_ref_25,
	input  wire logic                   clk_rcvr_125,
	input  wire logic                   clk_free_125,
	input  wire logic                   clk_hrt_rcvr,
	input  wire logic                   clk_hrt_free,
	output logic                        subsys_reset,
	output logic                        strap_resample_req,
	output logic [SSC_STRAP_W-1:0]      strap_cfg,
	output logic                        general_clock_output_pin
);
	typedef enum logic [3:0] {
		SQ_CAPTURE = 4'h1,
		SQ_IDLE    = 4'h2,
		SQ_HOLD    = 4'h4,
		SQ_LOAD    = 4'h8
	} ssc_seq_t;

	ssc_seq_t                 seq_r, seq_nxt;
	logic [SSC_SEQ_CNT_W-1:0] cnt_r, cnt_nxt;
	logic                     srst_r, srst_nxt, resamp_r, resamp_nxt, mode_r, mode_nxt;
	logic                     req_r, req_nxt, subrst_r, subrst_nxt, gp_r, gp_nxt;
	logic [SSC_CLK_SEL_W-1:0] clksel_r, clksel_nxt;
	logic [SSC_STRAP_W-1:0]   stored_r, stored_nxt, cfg_r, cfg_nxt;
	logic [SSC_STRAP_W-1:0]   strap_s1, strap_s2;
	logic [SSC_CLK_SEL_W-1:0] clk_src, clk_s1, clk_s2;
	logic [15:0]              reg_addr, wr_data, rd_data;
	logic                     wr_stb, wr_srst_one;

	// reserved bit 3 is stored and reads back but never competes for the pin
	localparam logic [SSC_CLK_SEL_W-1:0] CLK_EN_MASK = (6'h01 << SSC_BIT_RCVR_125)
		| (6'h01 << SSC_BIT_FREE_125) | (6'h01 << SSC_BIT_HRT_RCVR)
		| (6'h01 << SSC_BIT_HRT_FREE) | (6'h01 << SSC_BIT_REF_25);

	ssc_mdio_slave u_mdio (
		.mclk      (mclk),
		.reset     (reset),
		.mdc       (mdc),
		.mdio_in   (mdio_in),
		.phy_addr  (phy_addr),
		.rd_data   (rd_data),
		.mdio_out  (mdio_out),
		.mdio_oe_n (mdio_oe_n),
		.reg_addr  (reg_addr),
		.wr_data   (wr_data),
		.wr_stb    (wr_stb)
	);

	// bit 3 of the selector has no source behind it
	assign clk_src = {clk_rcvr_125, clk_free_125, 1'b0, clk_hrt_rcvr, clk_hrt_free, clk_ref_25};
	assign wr_srst_one = wr_stb && reg_addr == SSC_OFS_SOFT_RESET
		&& wr_data[SSC_BIT_SOFT_RESET];

	always_comb begin
		rd_data = SSC_RST_VAL;
		case (reg_addr)
		SSC_OFS_SOFT_RESET:     rd_data[SSC_BIT_SOFT_RESET] = srst_r;
		SSC_OFS_STRAP_RESAMPLE: rd_data[SSC_BIT_RESAMPLE] = resamp_r;
		SSC_OFS_CLK_SEL:        rd_data[SSC_CLK_SEL_W-1:0] = clksel_r;
		default:                rd_data = SSC_RST_VAL;
		endcase
	end

	always_comb begin
		seq_nxt    = seq_r;
		cnt_nxt    = cnt_r;
		srst_nxt   = srst_r;
		resamp_nxt = resamp_r;
		clksel_nxt = clksel_r;
		mode_nxt   = mode_r;
		req_nxt    = req_r;
		subrst_nxt = subrst_r;
		stored_nxt = stored_r;
		cfg_nxt    = cfg_r;
		case (seq_r)
		SQ_CAPTURE: begin
			// wait out the strap synchroniser before trusting its output
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == SSC_SEQ_CNT_W'(SSC_STRAP_SETTLE - 1)) begin
				stored_nxt = strap_s2;
				cfg_nxt    = strap_s2;
				cnt_nxt    = '0;
				seq_nxt    = SQ_IDLE;
			end
		end
		SQ_IDLE: begin
			if (srst_r) begin
				seq_nxt    = SQ_HOLD;
				cnt_nxt    = '0;
				subrst_nxt = 1'b1;
				mode_nxt   = resamp_r;
				req_nxt    = resamp_r;
			end
		end
		SQ_HOLD: begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == SSC_SEQ_CNT_W'(SSC_SRST_CYC - 1)) begin
				subrst_nxt = 1'b0;
				req_nxt    = 1'b0;
				cnt_nxt    = '0;
				seq_nxt    = SQ_LOAD;
			end
		end
		SQ_LOAD: begin
			if (mode_r) begin
				stored_nxt = strap_s2;
				cfg_nxt    = strap_s2;
			end else begin
				cfg_nxt = stored_r;
			end
			srst_nxt = 1'b0;
			seq_nxt  = SQ_IDLE;
		end
		default: begin
			seq_nxt = SQ_IDLE;
			cnt_nxt = '0;
		end
		endcase
		// a write of one in the completing cycle wins over the self-clear
		if (wr_srst_one)
			srst_nxt = 1'b1;
		if (wr_stb && reg_addr == SSC_OFS_STRAP_RESAMPLE)
			resamp_nxt = wr_data[SSC_BIT_RESAMPLE];
		if (wr_stb && reg_addr == SSC_OFS_CLK_SEL)
			clksel_nxt = wr_data[SSC_CLK_SEL_W-1:0];
	end

	// sampled copies only: the output is a 250 MHz retiming, not a clean clock tree path
	always_comb begin
		gp_nxt = 1'b0;
		for (int i = 0; i < SSC_CLK_SEL_W; i++) begin
			if (clksel_r[i] && CLK_EN_MASK[i])
				gp_nxt = clk_s2[i];
		end
	end

	always_ff @(posedge mclk) begin
		strap_s1 <= strap_pins;
		strap_s2 <= strap_s1;
		clk_s1   <= clk_src;
		clk_s2   <= clk_s1;
		if (reset) begin
			seq_r    <= SQ_CAPTURE;
			cnt_r    <= '0;
			srst_r   <= 1'b0;
			resamp_r <= 1'b0;
			clksel_r <= '0;
			mode_r   <= 1'b0;
			req_r    <= 1'b0;
			subrst_r <= 1'b0;
			stored_r <= '0;
			cfg_r    <= '0;
			gp_r     <= 1'b0;
		end else begin
			seq_r    <= seq_nxt;
			cnt_r    <= cnt_nxt;
			srst_r   <= srst_nxt;
			resamp_r <= resamp_nxt;
			clksel_r <= clksel_nxt;
			mode_r   <= mode_nxt;
			req_r    <= req_nxt;
			subrst_r <= subrst_nxt;
			stored_r <= stored_nxt;
			cfg_r    <= cfg_nxt;
			gp_r     <= gp_nxt;
		end
	end

	assign subsys_reset             = subrst_r;
	assign strap_resample_req       = req_r;
	assign strap_cfg                = cfg_r;
	assign general_clock_output_pin = gp_r;

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	a_srst_starts_seq: assert property (seq_r == SQ_IDLE && srst_r |=> subrst_r [*8])
		else $error("software reset did not hold the subsystem");
	a_resample_request: assert property (seq_r == SQ_IDLE && srst_r && resamp_r
		|=> req_r [*8] ##[1:30] seq_r == SQ_LOAD)
		else $error("strap resample not requested");
	a_reload_stored: assert property (seq_r == SQ_LOAD && !mode_r
		|=> cfg_r == $past(stored_r))
		else $error("stored straps not reloaded");
	a_rcvr_fast_out: assert property (clksel_r[5]
		|=> gp_r == $past(clk_s2[5]))
		else $error("recovered fast clock not selected");
	a_free_fast_out: assert property (clksel_r[4] && !clksel_r[5]
		|=> gp_r == $past(clk_s2[4]))
		else $error("free fast clock not selected");
	a_hrt_rcvr_out: assert property (clksel_r[2] && clksel_r[5:4] == 2'h0
		|=> gp_r == $past(clk_s2[2]))
		else $error("recovered heartbeat not selected");
	a_hrt_free_out: assert property (clksel_r[1] && clksel_r[5:4] == 2'h0 && !clksel_r[2]
		|=> gp_r == $past(clk_s2[1]))
		else $error("free heartbeat not selected");
	a_ref_clk_out: assert property ((clksel_r & CLK_EN_MASK) == 6'h01
		|=> gp_r == $past(clk_s2[0]))
		else $error("reference clock not selected");
	a_strap_capture: assert property (seq_r == SQ_CAPTURE
		&& cnt_r == SSC_SEQ_CNT_W'(SSC_STRAP_SETTLE - 1)
		|=> cfg_r == $past(strap_s2) && stored_r == cfg_r)
		else $error("straps not captured after reset");
	a_srst_self_clear: assert property (seq_r == SQ_LOAD && !wr_srst_one
		|=> !srst_r && seq_r == SQ_IDLE)
		else $error("software reset bit did not clear");
	a_no_sel_quiet: assert property ((clksel_r & CLK_EN_MASK) == 6'h00 |=> !gp_r)
		else $error("clock pin toggles with no source enabled");
	a_reg_write_path: assert property (wr_stb && reg_addr == SSC_OFS_CLK_SEL
		|=> clksel_r == $past(wr_data[5:0]))
		else $error("selector write lost");
endmodule // ssc_subsys_ctrl

/* File: test/ssc_mdio_host.sv */
`timescale 1ns/100ps
module ssc_mdio_host import ssc_pkg::*; (
	input  wire logic mclk,
	input  wire logic mdio_wire,
	output logic      mdc,
	output logic      mdo,
	output logic      drv
);
	initial begin
		mdc = 1'b0;
		mdo = 1'b1;
		drv = 1'b0;
	end
	// data changes while mdc is low; four mclk each phase gives the synchroniser margin
	task automatic bitc(input logic b, input logic d, output logic s);
		@(posedge mclk);
		mdc <= 1'b0;
		mdo <= b;
		drv <= d;
		repeat (4) @(posedge mclk);
		s = mdio_wire;
		mdc <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	// full preamble, header, turnaround and data, msb first
	task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa,
			input logic [4:0] ra, input logic [15:0] wd, input logic rd,
			output logic [16:0] q);
		logic [45:0] h;
		logic [17:0] td;
		logic        s;
		h = {32'hFFFFFFFF, st, op, pa, ra};
		td = {2'b10, wd};
		q = 17'h00000;
		for (int i = 45; i >= 0; i--) bitc(h[i], 1'b1, s);
		// on a read the line is released: the pull-up shows where the device is silent
		for (int i = 17; i >= 0; i--) begin
			bitc(td[i], !rd, s);
			q = {q[15:0], s};
		end
		@(posedge mclk);
		drv <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
endmodule // ssc_mdio_host

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench import ssc_pkg::*;;
	localparam logic [4:0] PHY = 5'h05;
	logic        mclk, reset, mdc, mdo, drv, mdio_out, mdio_oe_n, mdio_wire;
	logic        subsys_reset, strap_resample_req, gp, ck_en;
	logic [7:0]  strap_pins, strap_cfg, m_straps;
	logic [4:0]  src;
	logic [19:0] hist;
	logic [31:0] seed;
	int          num_errors, n_compared, cyc, m_sel, m_rsm, sr_len, sr_bad, sr_base;
	logic [16:0] q;
	logic [15:0] v;
	// pull-up on the shared data line
	assign mdio_wire = (mdio_oe_n === 1'b0) ? mdio_out : (drv ? mdo : 1'b1);
	ssc_subsys_ctrl i_dut (.mclk(mclk), .reset(reset), .mdc(mdc), .mdio_in(mdio_wire),
		.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(PHY), .strap_pins(strap_pins),
		.clk_ref_25(src[0]), .clk_rcvr_125(src[4]), .clk_free_125(src[3]),
		.clk_hrt_rcvr(src[2]), .clk_hrt_free(src[1]), .subsys_reset(subsys_reset),
		.strap_resample_req(strap_resample_req), .strap_cfg(strap_cfg),
		.general_clock_output_pin(gp));
	ssc_mdio_host i_host (.mclk(mclk), .mdio_wire(mdio_wire), .mdc(mdc), .mdo(mdo),
		.drv(drv));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic ck_exp(input int s, input logic [4:0] h);
		if (s[5]) return h[4];
		if (s[4]) return h[3];
		// reserved bit 3 never competes for the pin
		if (s[2]) return h[2];
		if (s[1]) return h[1];
		if (s[0]) return h[0];
		return 1'b0;
	endfunction
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr45(input logic [15:0] a, input logic [15:0] d);
		i_host.frame(2'b00, SSC_C45_OP_ADDR, PHY, SSC_DEVAD, a, 1'b0, q);
		i_host.frame(2'b00, SSC_C45_OP_WR, PHY, SSC_DEVAD, d, 1'b0, q);
	endtask
	// read frame only; turnaround low plus data must match
	task automatic rdo(input logic [1:0] st, input logic [1:0] op, input logic [4:0] ra,
			input logic [16:0] e);
		i_host.frame(st, op, PHY, ra, 16'h0000, 1'b1, q);
		chk(q, e);
	endtask
	task automatic rd45(input logic [15:0] a, input logic [15:0] e);
		i_host.frame(2'b00, SSC_C45_OP_ADDR, PHY, SSC_DEVAD, a, 1'b0, q);
		rdo(2'b00, 2'h3, SSC_DEVAD, {1'b0, e});
	endtask
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		src <= 5'(rnd());
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			end_of_test();
		end
	end
	// selected source seen three mclk later, sources toggle at random every cycle
	always @(negedge mclk) begin
		hist <= {hist[14:0], src};
		if (ck_en) chk(gp, ck_exp(m_sel, hist[14:10]));
		if (subsys_reset === 1'b1) begin
			sr_len++;
			if (strap_resample_req !== m_rsm[0]) sr_bad++;
		end else if (strap_resample_req !== 1'b0) begin
			sr_bad++;
		end
	end
	initial begin
		seed = 32'h6C1CDCD6;
		ck_en = 1'b0;
		reset <= 1'b1;
		strap_pins <= 8'h00;
		@(posedge mclk);
		strap_pins <= 8'(rnd());
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		m_straps = strap_pins;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk({9'h000, strap_cfg}, {9'h000, m_straps});
		chk({14'h0000, subsys_reset, strap_resample_req, mdio_oe_n}, 17'h00001);
		rd45(SSC_OFS_SOFT_RESET, SSC_RST_VAL);
		rd45(SSC_OFS_STRAP_RESAMPLE, SSC_RST_VAL);
		rd45(SSC_OFS_CLK_SEL, SSC_RST_VAL);
		wr45(16'hFF0E, 16'hFFFF);
		rd45(16'hFF0E, 16'h0000);
		wr45(SSC_OFS_STRAP_RESAMPLE, 16'hFFFF);
		i_host.frame(2'b00, SSC_C45_OP_ADDR, PHY, SSC_DEVAD, SSC_OFS_SOFT_RESET, 1'b0, q);
		rdo(2'b00, SSC_C45_OP_RDINC, SSC_DEVAD, 17'h00000);
		rdo(2'b00, 2'h3, SSC_DEVAD, 17'h00001);
		// refused frames: wrong device address and wrong management address stay silent
		i_host.frame(2'b00, 2'h3, PHY ^ 5'h01, SSC_DEVAD, 16'h0000, 1'b1, q);
		chk(q, 17'h1FFFF);
		rdo(2'b00, 2'h3, 5'h1D, 17'h1FFFF);
		i_host.frame(2'b01, SSC_C22_OP_WR, PHY, SSC_C22_PTR, SSC_OFS_CLK_SEL, 1'b0, q);
		rdo(2'b01, SSC_C22_OP_RD, SSC_C22_PTR, {1'b0, SSC_OFS_CLK_SEL});
		for (int i = 0; i < 10; i++) begin
			v = (i < 7) ? (16'h0020 >> i) : 16'(rnd());
			ck_en = 1'b0;
			i_host.frame(i[0] ? 2'b01 : 2'b00, 2'h1, PHY, i[0] ? SSC_C22_DATA : SSC_DEVAD,
				v, 1'b0, q);
			m_sel = int'(v[5:0]);
			rdo(2'b01, SSC_C22_OP_RD, SSC_C22_DATA, {11'h000, v[5:0]});
			ck_en = 1'b1;
			repeat (40) @(posedge mclk);
		end
		ck_en = 1'b0;
		// the sequence counters belong to the sampling process; take a baseline instead
		for (int mode = 1; mode >= 0; mode--) begin
			strap_pins <= 8'(rnd());
			wr45(SSC_OFS_STRAP_RESAMPLE, mode[15:0]);
			m_rsm = mode;
			sr_base = sr_len;
			wr45(SSC_OFS_SOFT_RESET, 16'h0000);
			wr45(SSC_OFS_SOFT_RESET, 16'hFFFF);
			repeat (60) @(posedge mclk);
			if (mode == 1) m_straps = strap_pins;
			@(negedge mclk);
			chk(17'(sr_len - sr_base), SSC_SRST_CYC[16:0]);
			chk(sr_bad[16:0], 17'h00000);
			chk({9'h000, strap_cfg}, {9'h000, m_straps});
			rd45(SSC_OFS_SOFT_RESET, 16'h0000);
		end
		end_of_test();
	end
endmodule // testbench
